// ---- hdl/ubg_pkg.sv ----
// package: register map, field positions and timing constants of the uart irq/baud block
package ubg_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_DIVISOR_LOW_BYTE = 8'h04;
  localparam logic [7:0] ADDR_DIVISOR_HIGH_BYTE = 8'h08;
  localparam logic [7:0] ADDR_SCRATCH_BYTE = 8'h0c;
  localparam logic [7:0] ADDR_MODEM_CONTROL_REG = 8'h10;
  localparam logic [7:0] ADDR_CHIP_CONFIG_TURBO_REG = 8'h14;
  localparam logic [7:0] ADDR_CHIP_CONFIG_FAST_REG = 8'h18;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h20;
  localparam logic [7:0] ADDR_SOURCE_STATE = 8'h24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int IER_USED_W = 4;
  localparam int MCR_IRQ_OUT_EN_BIT = 3;
  localparam int TURBO_A_BIT = 7;
  localparam int TURBO_B_BIT = 6;
  localparam int FAST_A_BIT = 1;
  localparam int FAST_B_BIT = 0;
  localparam int EVT_W = 2;
  localparam int EVT_UART_IRQ_BIT = 0;
  localparam int EVT_BUS_ERR_BIT = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;

  // ---------------------------------------------------------------
  // timing: 24 MHz reference made from the 125 MHz pclk
  // ---------------------------------------------------------------
  localparam int PCLK_MHZ = 125;
  localparam int REF_MHZ = 24;
  localparam int ACC_W = 8;
  localparam logic [ACC_W-1:0] REF_STEP = ACC_W'(REF_MHZ);
  localparam logic [ACC_W-1:0] REF_MOD = ACC_W'(PCLK_MHZ);
  // prescaler 24 MHz / 13 = 1.8461 MHz; fast mode steps 8 per tick (x8 rate)
  localparam int PRE_DIV = 13;
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_MOD = PRE_W'(PRE_DIV);
  localparam logic [PRE_W-1:0] PRE_STEP_NORMAL = 5'h01;
  localparam logic [PRE_W-1:0] PRE_STEP_FAST = 5'h08;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // pending interrupt conditions coming from the uart core
  typedef struct packed {
    logic modem_change;
    logic line_error;
    logic tx_empty;
    logic rx_ready;
  } ubg_src_s;

endpackage

// ---- hdl/ubg_top.sv ----
// module: uart interrupt enable, baud generator and scratch registers behind apb
//
// Summary of operation
// - enable register upper four bits read zero
// - modem change irq gated by enable bit 3
// - line error irq gated by enable bit 2
// - tx empty irq gated by enable bit 1
// - rx ready irq gated by enable bit 0
// - all four enables clear, no uart irq
// - divisor is two separate rw byte registers
// - normal mode prescales 24 MHz to 1.8461 MHz
// - divide prescaled clock by 1 to 65535
// - output is 16x bit rate timing base
// - turbo bits bypass prescaler, same divisor
// - turbo with divisor one gives 1.5 Mbit/s
// - normal rate is 115200 over divisor
// - fast bits give 921600 over divisor
// - scratch byte read/write, no side effects
// - modem control bit 3 gates uart irq
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ubg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ubg_pkg::ADDR_W-1:0] paddr,
  input wire logic [ubg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ubg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ubg_pkg::ubg_src_s uart_src,
  output logic uart_irq,
  output logic baud16_tick,
  output logic irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] irq_source_enable; // source enables, low four bits kept
  logic [7:0] divisor_low_byte; // divisor bits 7..0
  logic [7:0] divisor_high_byte; // divisor bits 15..8
  logic [7:0] scratch_byte; // free software storage
  logic [7:0] modem_control_reg; // only the irq output enable acts here
  logic [7:0] chip_config_turbo_reg; // turbo rate select bits
  logic [7:0] chip_config_fast_reg; // fast rate select bits
  logic [ubg_pkg::EVT_W-1:0] event_status; // sticky events, write one clears
  logic [ubg_pkg::EVT_W-1:0] event_mask; // per event interrupt enable
  logic [ubg_pkg::ACC_W-1:0] ref_acc; // phase of the 24 MHz reference
  logic [ubg_pkg::ACC_W-1:0] next_ref_acc; // phase after this cycle
  logic ref_tick; // one 24 MHz period elapsed
  logic [ubg_pkg::PRE_W-1:0] pre_acc; // prescaler phase
  logic [ubg_pkg::PRE_W-1:0] next_pre_acc; // prescaler phase after a ref tick
  logic pre_wrap; // prescaler crossed its modulus
  logic pre_tick; // one prescaled period elapsed
  logic [15:0] divisor; // assembled divisor
  logic [15:0] div_cnt; // baud down-counter
  logic turbo_on; // turbo rate selected
  logic fast_on; // fast rate selected
  logic [3:0] src_vec; // pending conditions as a vector
  logic [3:0] src_gated; // pending conditions passed by the enables
  logic setup; // apb setup phase
  logic access; // apb access phase, completes now
  logic wr_en; // write completes this cycle
  logic addr_ok; // address hits a register
  logic [7:0] wbyte; // low write byte
  logic [7:0] rbyte; // low read byte from the decoder
  logic [ubg_pkg::EVT_W-1:0] evt_set; // events raised this cycle
  logic [ubg_pkg::EVT_W-1:0] evt_clr; // bits cleared by software now

  // ---------------------------------------------------------------
  // address decode function
  // ---------------------------------------------------------------
  // true when the address names one of the registers
  function automatic logic is_mapped(input logic [ubg_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      ubg_pkg::ADDR_IRQ_SOURCE_ENABLE,
      ubg_pkg::ADDR_DIVISOR_LOW_BYTE,
      ubg_pkg::ADDR_DIVISOR_HIGH_BYTE,
      ubg_pkg::ADDR_SCRATCH_BYTE,
      ubg_pkg::ADDR_MODEM_CONTROL_REG,
      ubg_pkg::ADDR_CHIP_CONFIG_TURBO_REG,
      ubg_pkg::ADDR_CHIP_CONFIG_FAST_REG,
      ubg_pkg::ADDR_EVENT_STATUS,
      ubg_pkg::ADDR_EVENT_MASK,
      ubg_pkg::ADDR_SOURCE_STATE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // write hits one register when the address matches and lane 0 is enabled
  function automatic logic wr_hit(input logic [ubg_pkg::ADDR_W-1:0] a,
                                  input logic [ubg_pkg::ADDR_W-1:0] target,
                                  input logic en);
    return en && (a == target);
  endfunction

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign addr_ok = is_mapped(paddr);
  assign wr_en = access && pwrite && addr_ok && pstrb[0];
  assign wbyte = pwdata[7:0];
  // zero wait state slave: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;

  // ---------------------------------------------------------------
  // source enable register
  // ---------------------------------------------------------------
  // only the four enable bits are stored; upper bits never hold a one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_source_enable <= ubg_pkg::RST_BYTE;
    end else if (wr_hit(paddr, ubg_pkg::ADDR_IRQ_SOURCE_ENABLE, wr_en)) begin
      irq_source_enable <= {4'h0, wbyte[ubg_pkg::IER_USED_W-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // divisor byte registers
  // ---------------------------------------------------------------
  // two independent bytes, each read and written on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_byte <= ubg_pkg::RST_DIVISOR[7:0];
      divisor_high_byte <= ubg_pkg::RST_DIVISOR[15:8];
    end else begin
      if (wr_hit(paddr, ubg_pkg::ADDR_DIVISOR_LOW_BYTE, wr_en)) begin
        divisor_low_byte <= wbyte;
      end
      if (wr_hit(paddr, ubg_pkg::ADDR_DIVISOR_HIGH_BYTE, wr_en)) begin
        divisor_high_byte <= wbyte;
      end
    end
  end

  assign divisor = {divisor_high_byte, divisor_low_byte};

  // ---------------------------------------------------------------
  // scratch and configuration registers
  // ---------------------------------------------------------------
  // scratch steers nothing; the others pick rate and irq output enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_byte <= ubg_pkg::RST_BYTE;
      modem_control_reg <= ubg_pkg::RST_BYTE;
      chip_config_turbo_reg <= ubg_pkg::RST_BYTE;
      chip_config_fast_reg <= ubg_pkg::RST_BYTE;
    end else begin
      if (wr_hit(paddr, ubg_pkg::ADDR_SCRATCH_BYTE, wr_en)) begin
        scratch_byte <= wbyte;
      end
      if (wr_hit(paddr, ubg_pkg::ADDR_MODEM_CONTROL_REG, wr_en)) begin
        modem_control_reg <= wbyte;
      end
      if (wr_hit(paddr, ubg_pkg::ADDR_CHIP_CONFIG_TURBO_REG, wr_en)) begin
        chip_config_turbo_reg <= wbyte;
      end
      if (wr_hit(paddr, ubg_pkg::ADDR_CHIP_CONFIG_FAST_REG, wr_en)) begin
        chip_config_fast_reg <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // 24 MHz reference from pclk
  // ---------------------------------------------------------------
  // fractional accumulator: 24 ticks in every 125 pclk cycles
  always_comb begin
    next_ref_acc = ref_acc + ubg_pkg::REF_STEP;
    ref_tick = 1'b0;
    if (next_ref_acc >= ubg_pkg::REF_MOD) begin
      next_ref_acc = next_ref_acc - ubg_pkg::REF_MOD;
      ref_tick = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_acc <= '0;
    end else begin
      ref_acc <= next_ref_acc;
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  assign turbo_on = chip_config_turbo_reg[ubg_pkg::TURBO_A_BIT] ||
                    chip_config_turbo_reg[ubg_pkg::TURBO_B_BIT];
  assign fast_on = chip_config_fast_reg[ubg_pkg::FAST_A_BIT] ||
                   chip_config_fast_reg[ubg_pkg::FAST_B_BIT];

  // normal: one step per ref tick over 13, i.e. 1.8461 MHz
  // fast: eight steps over 13, eight times the normal rate
  always_comb begin
    next_pre_acc = pre_acc;
    pre_wrap = 1'b0;
    if (fast_on) begin
      next_pre_acc = pre_acc + ubg_pkg::PRE_STEP_FAST;
    end else begin
      next_pre_acc = pre_acc + ubg_pkg::PRE_STEP_NORMAL;
    end
    if (next_pre_acc >= ubg_pkg::PRE_MOD) begin
      next_pre_acc = next_pre_acc - ubg_pkg::PRE_MOD;
      pre_wrap = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_acc <= '0;
    end else if (ref_tick && !turbo_on) begin
      pre_acc <= next_pre_acc;
    end
  end

  // turbo feeds the 24 MHz reference straight into the divider
  assign pre_tick = turbo_on ? ref_tick : (ref_tick && pre_wrap);

  // ---------------------------------------------------------------
  // divisor down-counter
  // ---------------------------------------------------------------
  // expiry gives a one-cycle 16x tick and reloads from the live divisor;
  // a divisor of zero stops the generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= ubg_pkg::RST_DIVISOR;
      baud16_tick <= 1'b0;
    end else begin
      baud16_tick <= 1'b0;
      if (divisor == '0) begin
        div_cnt <= '0;
      end else if (pre_tick) begin
        if (div_cnt <= 16'h0001) begin
          div_cnt <= divisor;
          baud16_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt - 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // uart interrupt gating
  // ---------------------------------------------------------------
  assign src_vec = {uart_src.modem_change, uart_src.line_error,
                    uart_src.tx_empty, uart_src.rx_ready};

  // each pending condition passes only through its own enable bit
  genvar gi;
  generate
    for (gi = 0; gi < ubg_pkg::IER_USED_W; gi++) begin : g_gate
      assign src_gated[gi] = src_vec[gi] && irq_source_enable[gi];
    end
  endgenerate

  // registered output; needs an enabled source and the master enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_irq <= 1'b0;
    end else begin
      uart_irq <= (|src_gated) &&
                  modem_control_reg[ubg_pkg::MCR_IRQ_OUT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // event status and system interrupt
  // ---------------------------------------------------------------
  assign evt_set = {pslverr, uart_irq};
  assign evt_clr = wr_hit(paddr, ubg_pkg::ADDR_EVENT_STATUS, wr_en) ?
                   wbyte[ubg_pkg::EVT_W-1:0] : '0;

  // sticky bits: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= '0;
    end else begin
      event_status <= (event_status & ~evt_clr) | evt_set;
    end
  end

  // mask register, same layout as the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask <= '0;
    end else if (wr_hit(paddr, ubg_pkg::ADDR_EVENT_MASK, wr_en)) begin
      event_mask <= wbyte[ubg_pkg::EVT_W-1:0];
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((event_status & ~evt_clr | evt_set) & event_mask);
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // decode the addressed byte; unmapped addresses read zero
  always_comb begin
    rbyte = 8'h00;
    unique case (paddr)
      ubg_pkg::ADDR_IRQ_SOURCE_ENABLE: rbyte = {4'h0, irq_source_enable[3:0]};
      ubg_pkg::ADDR_DIVISOR_LOW_BYTE: rbyte = divisor_low_byte;
      ubg_pkg::ADDR_DIVISOR_HIGH_BYTE: rbyte = divisor_high_byte;
      ubg_pkg::ADDR_SCRATCH_BYTE: rbyte = scratch_byte;
      ubg_pkg::ADDR_MODEM_CONTROL_REG: rbyte = modem_control_reg;
      ubg_pkg::ADDR_CHIP_CONFIG_TURBO_REG: rbyte = chip_config_turbo_reg;
      ubg_pkg::ADDR_CHIP_CONFIG_FAST_REG: rbyte = chip_config_fast_reg;
      ubg_pkg::ADDR_EVENT_STATUS: rbyte = {6'h00, event_status};
      ubg_pkg::ADDR_EVENT_MASK: rbyte = {6'h00, event_mask};
      ubg_pkg::ADDR_SOURCE_STATE: rbyte = {3'h0, uart_irq, src_vec};
      default: rbyte = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rbyte};
    end
  end

endmodule

// ---- verif/ubg_chk.sv ----
// checker: concurrent properties on the ports of ubg_top
`timescale 1ns/1ps
module ubg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ubg_pkg::ADDR_W-1:0] paddr,
  input wire logic [ubg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [ubg_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ubg_pkg::ubg_src_s uart_src,
  input wire logic uart_irq,
  input wire logic baud16_tick,
  input wire logic irq
);
  // ----------------------------------------------
  // shadow copies built from completed apb writes
  // ----------------------------------------------
  logic [7:0] sh_ier; // enable byte, upper nibble held zero
  logic [7:0] sh_lo; // divisor low byte
  logic [7:0] sh_hi; // divisor high byte
  logic [7:0] sh_scr; // scratch byte
  logic sh_mcr; // irq output enable copy
  logic [7:0] exp_rd; // expected low byte of a read
  logic known; // address is one of the shadowed byte registers (enable, divisor, scratch)
  logic exp_irq; // uart irq due one cycle later
  logic acc; // access phase of a transfer

  assign acc = psel && penable;
  // a write stores only in the access phase with lane 0 enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ier <= 8'h00;
      sh_lo <= 8'h00;
      sh_hi <= 8'h00;
      sh_scr <= 8'h00;
      sh_mcr <= 1'b0;
    end else if (acc && pwrite && pstrb[0]) begin
      case (paddr)
        ubg_pkg::ADDR_IRQ_SOURCE_ENABLE: sh_ier <= {4'h0, pwdata[3:0]};
        ubg_pkg::ADDR_DIVISOR_LOW_BYTE: sh_lo <= pwdata[7:0];
        ubg_pkg::ADDR_DIVISOR_HIGH_BYTE: sh_hi <= pwdata[7:0];
        ubg_pkg::ADDR_SCRATCH_BYTE: sh_scr <= pwdata[7:0];
        ubg_pkg::ADDR_MODEM_CONTROL_REG: sh_mcr <= pwdata[ubg_pkg::MCR_IRQ_OUT_EN_BIT];
        default: ;
      endcase
    end
  end
  // readback value of the shadowed byte registers
  always_comb begin
    known = 1'b1;
    case (paddr)
      ubg_pkg::ADDR_IRQ_SOURCE_ENABLE: exp_rd = sh_ier;
      ubg_pkg::ADDR_DIVISOR_LOW_BYTE: exp_rd = sh_lo;
      ubg_pkg::ADDR_DIVISOR_HIGH_BYTE: exp_rd = sh_hi;
      ubg_pkg::ADDR_SCRATCH_BYTE: exp_rd = sh_scr;
      default: begin
        exp_rd = 8'h00;
        known = 1'b0;
      end
    endcase
  end
  assign exp_irq = (|(uart_src & sh_ier[3:0])) && sh_mcr;

  // ----------------------------------------------
  // properties
  // ----------------------------------------------
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    acc |-> pready) else $error("pready low in access phase");
  a_err_map: assert property (@(posedge pclk) disable iff (!presetn)
    acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h24))
    else $error("pslverr does not match address map");
  a_rd_upper: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("read data upper bits set");
  a_ier_upper: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == ubg_pkg::ADDR_IRQ_SOURCE_ENABLE |-> prdata[7:4] == 4'h0)
    else $error("enable register upper nibble not zero");
  a_reg_readback: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && known |-> prdata[7:0] == exp_rd) else $error("register readback differs");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> uart_irq == $past(exp_irq)) else $error("uart irq not gated by enables");
  a_tick_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    baud16_tick |=> !baud16_tick) else $error("baud tick longer than one cycle");
  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    baud16_tick |=> !baud16_tick [*4]) else $error("baud ticks closer than reference rate");
endmodule

bind ubg_top ubg_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .uart_src, .uart_irq, .baud16_tick, .irq);

// ---- verif/ubg_host.sv ----
// host model: apb master issuing register transfers to the block
`timescale 1ns/1ps
module ubg_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end
  // setup cycle, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- verif/tb_ubg_top.sv ----
// testbench: register, interrupt and baud rate tests for ubg_top
`timescale 1ns/1ps
module tb_ubg_top;
  // ----------------------------------------------
  // signals and address aliases
  // ----------------------------------------------
  localparam logic [7:0] A_IER = ubg_pkg::ADDR_IRQ_SOURCE_ENABLE;
  localparam logic [7:0] A_MCR = ubg_pkg::ADDR_MODEM_CONTROL_REG;
  localparam logic [7:0] A_STS = ubg_pkg::ADDR_EVENT_STATUS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, uart_irq, baud16_tick, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic err; // error response of the last transfer
  ubg_pkg::ubg_src_s uart_src;
  int errors, compares, ticks, cyc, base;

  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      $display("timeout");
      end_sim();
    end
  end
  // ticks counted away from the edge that launches them
  always @(negedge pclk) begin
    if (baud16_tick === 1'b1) ticks++;
  end

  ubg_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ubg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .uart_src(uart_src), .uart_irq(uart_irq),
    .baud16_tick(baud16_tick), .irq(irq));

  // ----------------------------------------------
  // compare and access tasks
  // ----------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  // rate counts carry two ticks of slack for window edges and jitter
  task automatic chk_cnt(input string name, input int exp, input int got);
    compares++;
    if (got < exp - 2 || got > exp + 2) begin
      errors++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h00_0000, d}, rd, err);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(name, exp, rd);
  endtask
  // k is prescaled ticks per 13 reference ticks: 13 turbo, 8 fast, 1 normal
  task automatic rate(input logic [7:0] tur, input logic [7:0] fst, input int d, input int k);
    wr(ubg_pkg::ADDR_CHIP_CONFIG_TURBO_REG, tur);
    wr(ubg_pkg::ADDR_CHIP_CONFIG_FAST_REG, fst);
    // a zero divisor clears the counter, so a long old count cannot linger
    wr(ubg_pkg::ADDR_DIVISOR_HIGH_BYTE, 8'h00);
    wr(ubg_pkg::ADDR_DIVISOR_LOW_BYTE, 8'h00);
    wr(ubg_pkg::ADDR_DIVISOR_LOW_BYTE, d[7:0]);
    wr(ubg_pkg::ADDR_DIVISOR_HIGH_BYTE, d[15:8]);
    repeat (1000) @(posedge pclk);
    base = ticks;
    repeat (6500) @(posedge pclk);
    chk_cnt("tick count", 6500 * 24 * k / (125 * 13 * d), ticks - base);
  endtask
  task automatic src_chk(input logic [3:0] s, input logic exp);
    @(posedge pclk);
    uart_src <= s;
    repeat (2) @(posedge pclk);
    chk_bit("uart_irq", exp, uart_irq);
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------
  // test sequence
  // ----------------------------------------------
  initial begin
    presetn = 1'b0;
    uart_src = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values; divisor zero keeps the generator still
    rd_chk("enable", A_IER, 32'h0000_0000);
    rd_chk("divisor low", ubg_pkg::ADDR_DIVISOR_LOW_BYTE, 32'h0000_0000);
    rd_chk("scratch", ubg_pkg::ADDR_SCRATCH_BYTE, 32'h0000_0000);
    repeat (200) @(posedge pclk);
    chk("idle ticks", 32'h0000_0000, 32'(ticks));
    $display("test reset done");
    // register access
    wr(A_IER, 8'hff);
    rd_chk("enable", A_IER, 32'h0000_000f);
    wr(ubg_pkg::ADDR_DIVISOR_LOW_BYTE, 8'ha5);
    wr(ubg_pkg::ADDR_DIVISOR_HIGH_BYTE, 8'h5a);
    wr(ubg_pkg::ADDR_SCRATCH_BYTE, 8'h3c);
    rd_chk("divisor low", ubg_pkg::ADDR_DIVISOR_LOW_BYTE, 32'h0000_00a5);
    rd_chk("divisor high", ubg_pkg::ADDR_DIVISOR_HIGH_BYTE, 32'h0000_005a);
    rd_chk("scratch", ubg_pkg::ADDR_SCRATCH_BYTE, 32'h0000_003c);
    rd_chk("enable", A_IER, 32'h0000_000f);
    $display("test registers done");
    // each enable bit against each source
    wr(A_MCR, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(A_IER, 8'(1 << i));
      for (int j = 0; j < 4; j++) begin
        src_chk(4'(1 << j), i == j);
      end
    end
    wr(A_IER, 8'h00);
    src_chk(4'hf, 1'b0);
    wr(A_IER, 8'h0f);
    wr(A_MCR, 8'h00);
    src_chk(4'hf, 1'b0);
    wr(A_MCR, 8'h08);
    src_chk(4'hf, 1'b1);
    rd_chk("source state", ubg_pkg::ADDR_SOURCE_STATE, 32'h0000_001f);
    src_chk(4'h0, 1'b0);
    $display("test source gating done");
    // events: a mask bit of one lets its event through; write one clears
    wr(A_STS, 8'h03);
    rd_chk("status", A_STS, 32'h0000_0000);
    wr(ubg_pkg::ADDR_EVENT_MASK, 8'h02);
    host.xfer(1'b0, 8'h30, 32'h0000_0000, rd, err);
    chk("unmapped read", 32'h0000_0000, rd);
    chk_bit("pslverr", 1'b1, err);
    repeat (2) @(posedge pclk);
    chk_bit("irq", 1'b1, irq);
    rd_chk("status", A_STS, 32'h0000_0002);
    wr(ubg_pkg::ADDR_EVENT_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    chk_bit("irq masked", 1'b0, irq);
    wr(ubg_pkg::ADDR_EVENT_MASK, 8'h02);
    repeat (2) @(posedge pclk);
    chk_bit("irq unmasked", 1'b1, irq);
    wr(A_STS, 8'h02);
    repeat (2) @(posedge pclk);
    chk_bit("irq cleared", 1'b0, irq);
    rd_chk("status", A_STS, 32'h0000_0000);
    $display("test events done");
    // baud rates across normal, fast and turbo settings
    rate(8'h00, 8'h00, 1, 1);
    rate(8'h00, 8'h00, 12, 1);
    rate(8'h00, 8'h02, 4, 8);
    rate(8'h00, 8'h02, 2, 8);
    rate(8'h00, 8'h01, 1, 8);
    rate(8'h80, 8'h00, 1, 13);
    rate(8'h40, 8'h02, 3, 13);
    $display("test baud rates done");
    end_sim();
  end
endmodule
